/* File: verilog/scs_top.sv */
// Chip-select sequencer, SPI pin wiring and coarse delay measurement
// Functional notes
// - A stop command aborts any coarse delay measurement and halts it.
// - A successful measurement ends itself without needing a stop.
// - Clock on port B line one, out on C line seven, in on B zero.
// - Setup makes the chosen select pin an output at inactive level.
// - Select port index 1000 or more leaves all pins unconfigured.
// - Before each transfer the select pin goes active.
// - After the transfer completes the select pin returns inactive.
// - Select port index 1000 or more never toggles any select pin.
// - Clock rate and idle level may change between transfers.
module scs_top
  import scs_pkg::*;
(
  input  wire logic                    mclk_i,
  input  wire logic                    rst_n_i,
  input  wire logic                    setup_i,
  input  wire scs_pkg::scs_cfg_type    cfg_i,
  input  wire scs_pkg::scs_byte_type   tx_i,
  input  wire logic                    last_i,
  output logic                         tx_ready_o,
  output scs_pkg::scs_byte_type        rx_o,
  output logic                         xfer_done_o,
  input  wire logic                    port_b_line_zero_i,
  output logic                         port_b_line_one_o,
  output logic                         port_c_line_seven_o,
  output logic [NUM_PORTS*PORT_PINS-1:0] pin_o,
  output logic [NUM_PORTS*PORT_PINS-1:0] pin_oe_n_o,
  input  wire scs_pkg::scs_meas_cmd_type meas_i,
  input  wire logic                    coarse_delay_abort_i,
  input  wire logic                    monitor_pin_i,
  output logic                         excite_o,
  output logic                         meas_busy_o,
  output logic                         meas_done_o,
  output logic [MEAS_W-1:0]            meas_count_o
);
  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_SELECT = 4'b0010,
    ST_SHIFT  = 4'b0100,
    ST_WAIT   = 4'b1000
  } scs_state_type;

  localparam int PINS = NUM_PORTS * PORT_PINS;

  function automatic logic sel_off(input logic [15:0] port);
    sel_off = (port >= SELECT_OFF_MIN);
  endfunction

  function automatic logic [PINS-1:0] pin_mask(input logic [15:0] port,
                                               input logic [2:0]  bitn);
    logic [PINS-1:0] m;
    m = '0;
    if (port < 16'(NUM_PORTS))
      m[port[2:0]*PORT_PINS + int'(bitn)] = 1'b1;
    pin_mask = m;
  endfunction

  scs_state_type   state, next_state;
  scs_cfg_type     cfg, next_cfg;
  logic [PINS-1:0] pins, next_pins, oe_n, next_oe_n;
  logic            cs_act, next_cs_act;
  logic [7:0]      txb, next_txb;
  logic            last, next_last;
  scs_byte_type    rx, next_rx;
  logic            xdone, next_xdone;
  logic            sh_start, sh_busy, sh_done;
  logic [7:0]      sh_rx;
  logic            mon_m, mon_s;
  logic            mbusy, next_mbusy, mdone, next_mdone, exc, next_exc;
  logic            det_lvl, next_det_lvl;
  logic [MEAS_W-1:0] mcnt, next_mcnt;
  logic [PINS-1:0] msk;

  scs_shifter u_shift (
    .mclk_i        (mclk_i),
    .rst_n_i       (rst_n_i),
    .start_i       (sh_start),
    .tx_i          (txb),
    .half_period_i (cfg.half_period),
    .idle_high_i   (cfg.clk_idle_high),
    .miso_i        (port_b_line_zero_i),
    .sclk_o        (port_b_line_one_o),
    .mosi_o        (port_c_line_seven_o),
    .busy_o        (sh_busy),
    .done_o        (sh_done),
    .rx_o          (sh_rx)
  );

  assign msk        = pin_mask(cfg.port_index, cfg.bit_index);
  assign tx_ready_o = (state == ST_IDLE) && !setup_i;
  assign sh_start   = (state == ST_SELECT);

  always_comb
  begin
    next_state  = state;
    next_cfg    = cfg;
    next_pins   = pins;
    next_oe_n   = oe_n;
    next_cs_act = cs_act;
    next_txb    = txb;
    next_last   = last;
    next_rx     = rx;
    next_rx.valid = 1'b0;
    next_xdone  = 1'b0;
    case (state)
      ST_IDLE:
      begin
        if (setup_i)
        begin
          // Config only changes here, between transfers
          next_cfg = cfg_i;
          if (!sel_off(cfg_i.port_index))
          begin
            next_oe_n = oe_n & ~pin_mask(cfg_i.port_index, cfg_i.bit_index);
            next_pins = cfg_i.inactive_level
                      ? (pins | pin_mask(cfg_i.port_index, cfg_i.bit_index))
                      : (pins & ~pin_mask(cfg_i.port_index, cfg_i.bit_index));
          end
        end
        else if (tx_i.valid)
        begin
          next_txb  = tx_i.data;
          next_last = last_i;
          if (!cs_act && !sel_off(cfg.port_index))
          begin
            next_pins = cfg.inactive_level ? (pins & ~msk) : (pins | msk);
            next_cs_act = 1'b1;
          end
          next_state = ST_SELECT;
        end
      end
      ST_SELECT:
        next_state = ST_SHIFT;
      ST_SHIFT:
        next_state = ST_WAIT;
      ST_WAIT:
      begin
        if (sh_done)
        begin
          next_rx.valid = 1'b1;
          next_rx.data  = sh_rx;
          next_state    = ST_IDLE;
          if (last)
          begin
            next_xdone = 1'b1;
            if (cs_act)
            begin
              // Pin from the current config, so a setup between bytes of one select can move it
              next_pins = cfg.inactive_level ? (pins | msk) : (pins & ~msk);
              next_cs_act = 1'b0;
            end
          end
        end
      end
      default:
        next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state  <= ST_IDLE;
      cfg    <= '{SELECT_OFF_MIN, 3'h0, CS_INACTIVE_RST, DIV_RST, CPOL_RST};
      pins   <= '1;
      oe_n   <= '1;
      cs_act <= 1'b0;
      txb    <= BYTE_RST;
      last   <= 1'b0;
      rx     <= '0;
      xdone  <= 1'b0;
    end
    else
    begin
      state  <= next_state;
      cfg    <= next_cfg;
      pins   <= next_pins;
      oe_n   <= next_oe_n;
      cs_act <= next_cs_act;
      txb    <= next_txb;
      last   <= next_last;
      rx     <= next_rx;
      xdone  <= next_xdone;
    end
  end

  assign pin_o       = pins;
  assign pin_oe_n_o  = oe_n;
  assign rx_o        = rx;
  assign xfer_done_o = xdone;

  // Coarse delay measurement: excite, count until the monitor pin matches
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      mon_m <= 1'b0;
      mon_s <= 1'b0;
    end
    else
    begin
      mon_m <= monitor_pin_i;
      mon_s <= mon_m;
    end
  end

  always_comb
  begin
    next_mbusy   = mbusy;
    next_mdone   = mdone;
    next_exc     = exc;
    next_det_lvl = det_lvl;
    next_mcnt    = mcnt;
    if (coarse_delay_abort_i || meas_i.stop)
    begin
      // Abort wins over a start in the same cycle
      next_mbusy = 1'b0;
      next_exc   = 1'b0;
    end
    else if (meas_i.start && !mbusy)
    begin
      next_mbusy   = 1'b1;
      next_mdone   = 1'b0;
      next_exc     = meas_i.excite_level;
      next_det_lvl = meas_i.detect_level;
      next_mcnt    = MEAS_RST;
    end
    else if (mbusy)
    begin
      if (mon_s == det_lvl)
      begin
        next_mbusy = 1'b0;
        next_mdone = 1'b1;
        next_exc   = 1'b0;
      end
      else
        next_mcnt = mcnt + 32'h1;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      mbusy   <= 1'b0;
      mdone   <= 1'b0;
      exc     <= 1'b0;
      det_lvl <= 1'b0;
      mcnt    <= MEAS_RST;
    end
    else
    begin
      mbusy   <= next_mbusy;
      mdone   <= next_mdone;
      exc     <= next_exc;
      det_lvl <= next_det_lvl;
      mcnt    <= next_mcnt;
    end
  end

  assign excite_o     = exc;
  assign meas_busy_o  = mbusy;
  assign meas_done_o  = mdone;
  assign meas_count_o = mcnt;
endmodule

/* File: verilog/scs_pkg.sv */
// Package of constants and carrier types for the chip-select sequencer
package scs_pkg;
  localparam int          PORT_W          = 16;
  localparam int          BIT_W           = 3;
  localparam int          NUM_PORTS       = 5;
  localparam int          PORT_PINS       = 8;
  localparam logic [15:0] SELECT_OFF_MIN  = 16'h03E8;
  localparam logic        CS_INACTIVE_RST = 1'b1;
  localparam logic [7:0]  DIV_RST         = 8'h01;
  localparam logic        CPOL_RST        = 1'b0;
  localparam int          MEAS_W          = 32;
  localparam logic [31:0] MEAS_RST        = 32'h0000_0000;
  localparam logic [7:0]  BYTE_RST        = 8'h00;
  localparam logic [3:0]  BITCNT_RST      = 4'h0;

  typedef struct packed {
    logic [15:0] port_index;
    logic [2:0]  bit_index;
    logic        inactive_level;
    logic [7:0]  half_period;
    logic        clk_idle_high;
  } scs_cfg_type;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } scs_byte_type;

  typedef struct packed {
    logic start;
    logic stop;
    logic excite_level;
    logic detect_level;
  } scs_meas_cmd_type;
endpackage

/* File: verilog/scs_shifter.sv */
// Byte-wide SPI shift engine with programmable clock rate and idle level
module scs_shifter
  import scs_pkg::*;
(
  input  wire logic       mclk_i,
  input  wire logic       rst_n_i,
  input  wire logic       start_i,
  input  wire logic [7:0] tx_i,
  input  wire logic [7:0] half_period_i,
  input  wire logic       idle_high_i,
  input  wire logic       miso_i,
  output logic            sclk_o,
  output logic            mosi_o,
  output logic            busy_o,
  output logic            done_o,
  output logic [7:0]      rx_o
);
  logic       busy, next_busy, done, next_done, sclk, next_sclk;
  logic [7:0] sh, next_sh, rx, next_rx, div, next_div;
  logic [3:0] edges, next_edges;
  logic       miso_m, miso_s;

  // Data line comes from a pin: two flops before use
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      miso_m <= 1'b0;
      miso_s <= 1'b0;
    end
    else
    begin
      miso_m <= miso_i;
      miso_s <= miso_m;
    end
  end

  always_comb
  begin
    next_busy  = busy;
    next_done  = 1'b0;
    next_sclk  = sclk;
    next_sh    = sh;
    next_rx    = rx;
    next_div   = div;
    next_edges = edges;
    if (!busy)
    begin
      next_sclk = idle_high_i;
      if (start_i)
      begin
        next_busy  = 1'b1;
        next_sh    = tx_i;
        next_div   = half_period_i;
        next_edges = BITCNT_RST;
      end
    end
    else if (div <= 8'h01)
    begin
      next_div  = half_period_i;
      next_sclk = ~sclk;
      // Even edges are leading: sample; odd edges trail: shift
      if (!edges[0])
        next_rx = {rx[6:0], miso_s};
      else
        next_sh = {sh[6:0], 1'b0};
      next_edges = edges + 4'h1;
      if (edges == 4'hF)
      begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end
    end
    else
      next_div = div - 8'h01;
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      busy  <= 1'b0;
      done  <= 1'b0;
      sclk  <= CPOL_RST;
      sh    <= BYTE_RST;
      rx    <= BYTE_RST;
      div   <= DIV_RST;
      edges <= BITCNT_RST;
    end
    else
    begin
      busy  <= next_busy;
      done  <= next_done;
      sclk  <= next_sclk;
      sh    <= next_sh;
      rx    <= next_rx;
      div   <= next_div;
      edges <= next_edges;
    end
  end

  assign sclk_o = sclk;
  assign mosi_o = sh[7];
  assign busy_o = busy;
  assign done_o = done;
  assign rx_o   = rx;
endmodule

/* File: verif/scs_checker.sv */
// Port assertions for the chip-select sequencer
module scs_checker
  import scs_pkg::*;
(
  input wire logic                 mclk_i,
  input wire logic                 rst_n_i,
  input wire logic                 setup_i,
  input wire scs_pkg::scs_cfg_type cfg_i,
  input wire scs_pkg::scs_byte_type tx_i,
  input wire logic                 tx_ready_o,
  input wire logic                 xfer_done_o,
  input wire scs_pkg::scs_byte_type rx_o,
  input wire logic                 port_b_line_one_o,
  input wire logic [39:0]          pin_o,
  input wire logic [39:0]          pin_oe_n_o,
  input wire scs_pkg::scs_meas_cmd_type meas_i,
  input wire logic                 coarse_delay_abort_i,
  input wire logic                 excite_o,
  input wire logic                 meas_busy_o,
  input wire logic                 meas_done_o
);
  scs_cfg_type cfg_q;
  logic [5:0]  idx;
  logic        on;
  logic        take;
  logic        quit;
  logic        inflight;
  logic        cfg_take;
  assign idx  = {cfg_q.port_index[2:0], cfg_q.bit_index};
  // Ready is low while setup is high, so idle is tracked from bytes
  assign cfg_take = setup_i && (!inflight || rx_o.valid);
  assign on   = cfg_q.port_index < 16'(NUM_PORTS);
  assign take = tx_i.valid && tx_ready_o;
  assign quit = coarse_delay_abort_i || meas_i.stop;
  always_ff @(posedge mclk_i or negedge rst_n_i)
    if (!rst_n_i)
      inflight <= 1'b0;
    else if (take)
      inflight <= 1'b1;
    else if (rx_o.valid)
      inflight <= 1'b0;
  // Shadow of the latched setup, so pin checks know the managed pin
  always_ff @(posedge mclk_i or negedge rst_n_i)
    if (!rst_n_i)
      cfg_q <= '{SELECT_OFF_MIN, 3'h0, CS_INACTIVE_RST, DIV_RST, CPOL_RST};
    else if (cfg_take)
      cfg_q <= cfg_i;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  AST_CFG_PIN: assert property (
    cfg_take && cfg_i.port_index < 16'(NUM_PORTS) |=>
    ##[0:2] (!pin_oe_n_o[idx] && pin_o[idx] == cfg_q.inactive_level))
    else $error("select pin not set up");
  AST_NO_CFG: assert property (
    cfg_take && cfg_i.port_index >= SELECT_OFF_MIN |=>
    $stable(pin_oe_n_o) [*3]) else $error("pin enables changed");
  AST_CS_ON: assert property (
    on && $changed(pin_o[idx]) && pin_o[idx] != cfg_q.inactive_level
    |-> $past(take)) else $error("select active without a byte");
  AST_CS_OFF: assert property (
    on && xfer_done_o |-> pin_o[idx] == cfg_q.inactive_level)
    else $error("select left active");
  AST_NO_TOGGLE: assert property (
    !on && !$past(on) |-> $stable(pin_o) && $stable(pin_oe_n_o))
    else $error("pin toggled while disabled");
  AST_SCLK_IDLE: assert property (
    xfer_done_o |-> port_b_line_one_o == cfg_q.clk_idle_high)
    else $error("clock not at idle level");
  AST_MEAS_QUIT: assert property (
    quit |=> !meas_busy_o && !excite_o) else $error("measurement kept on");
  AST_MEAS_DONE: assert property (
    $fell(meas_busy_o) && !$past(quit) |-> meas_done_o)
    else $error("measurement ended without done");
  cover property (xfer_done_o && on);
  cover property ($fell(meas_busy_o) && meas_done_o);
  cover property (setup_i && cfg_i.port_index >= SELECT_OFF_MIN);
endmodule

bind scs_top scs_checker u_scs_checker (.mclk_i, .rst_n_i, .setup_i,
  .cfg_i, .tx_i, .tx_ready_o, .xfer_done_o, .rx_o, .port_b_line_one_o, .pin_o,
  .pin_oe_n_o, .meas_i, .coarse_delay_abort_i, .excite_o, .meas_busy_o,
  .meas_done_o);

/* File: verif/scs_periph.sv */
// Behavioural SPI peripheral that answers only while selected
module scs_periph
(
  input  wire logic       mclk_i,
  input  wire logic       sclk_i,
  input  wire logic       mosi_i,
  input  wire logic       sel_n_i,
  input  wire logic       idle_high_i,
  input  wire logic [7:0] resp_i,
  output logic            miso_o,
  output logic [7:0]      got_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh = 8'h00;
  logic [2:0] cnt = 3'h0;
  logic       noise = 1'b0;
  initial
    got_o = 8'h00;
  // Bit count restarts per byte, so a multi-byte select reloads the reply
  always @(negedge sel_n_i)
    cnt = 3'h0;
  always @(sclk_i)
    if (!sel_n_i)
    begin
      if (sclk_i != idle_high_i)
        got_o = {got_o[6:0], mosi_i};
      else
      begin
        sh = (cnt == 3'h0) ? {resp_i[6:0], 1'b0} : {sh[6:0], 1'b0};
        cnt = cnt + 3'h1;
      end
    end
  // Unselected, the line wanders so a stale bit never passes as data
  always @(posedge mclk_i)
    noise <= ~noise;
  assign miso_o = sel_n_i ? noise : ((cnt == 3'h0) ? resp_i[7] : sh[7]);
endmodule

/* File: verif/scs_top_bench.sv */
// Self-checking bench for the chip-select sequencer
module scs_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import scs_pkg::*;
  localparam int CS = 11;
  logic             mclk_i = 1'b0, rst_n_i = 1'b0, setup_i = 1'b0;
  logic             last_i = 1'b0, abort = 1'b0, monitor = 1'b0;
  scs_cfg_type      cfg_i = '0;
  scs_byte_type     tx_i = '0;
  scs_meas_cmd_type meas_i = '0;
  scs_byte_type     rx_o;
  logic             tx_ready_o, xfer_done_o, sclk, mosi, miso, excite_o;
  logic             meas_busy_o, meas_done_o;
  logic [39:0]      pin_o, pin_oe_n_o, snap;
  logic [31:0]      meas_count_o;
  logic [7:0]       resp = 8'h00, pgot;
  int               miscompares = 0, checked = 0, cycles = 0;

  scs_top u_scs_top (.mclk_i, .rst_n_i, .setup_i, .cfg_i, .tx_i, .last_i,
    .tx_ready_o, .rx_o, .xfer_done_o, .port_b_line_zero_i(miso),
    .port_b_line_one_o(sclk), .port_c_line_seven_o(mosi), .pin_o,
    .pin_oe_n_o, .meas_i, .coarse_delay_abort_i(abort),
    .monitor_pin_i(monitor), .excite_o, .meas_busy_o, .meas_done_o,
    .meas_count_o);
  scs_periph u_scs_periph (.mclk_i, .sclk_i(sclk), .mosi_i(mosi),
    .sel_n_i(pin_o[CS]), .idle_high_i(cfg_i.clk_idle_high),
    .resp_i(resp), .miso_o(miso), .got_o(pgot));

  always #20 mclk_i = ~mclk_i;

  task automatic test_done();
    $display("Checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Ceiling is well above the few hundred cycles the run needs
  always @(posedge mclk_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      test_done();
    end
  end

  task automatic chk(input string what, input logic [39:0] exp, got);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #2;
  endtask

  task automatic setup(input logic [15:0] p, input logic [7:0] hp,
                       input logic idle);
    cfg_i = '{p, 3'h3, 1'b1, hp, idle};
    setup_i = 1'b1;
    tick(1);
    setup_i = 1'b0;
    tick(3);
  endtask

  // One byte; on says the managed select pin is expected to move
  task automatic xfer(input logic [7:0] d, r, input logic last, on);
    int n;
    resp = r;
    tx_i = '{1'b1, d};
    last_i = last;
    for (n = 0; n < 100 && tx_ready_o !== 1'b1; n++)
      tick(1);
    tick(1);
    tx_i.valid = 1'b0;
    tick(1);
    if (on)
      chk("select on", 40'h0, pin_o[CS]);
    for (n = 0; n < 400 && rx_o.valid !== 1'b1; n++)
      tick(1);
    chk("rx valid", 40'h1, rx_o.valid);
    chk("xfer done", last, xfer_done_o);
    if (on)
    begin
      chk("rx byte", r, rx_o.data);
      chk("chip byte", d, pgot);
      chk("select end", last, pin_o[CS]);
    end
  endtask

  task automatic t_cs();
    chk("reset pins", '1, pin_o);
    chk("reset enables", '1, pin_oe_n_o);
    setup(16'h0001, 8'h04, 1'b0);
    chk("enables", ~(40'h1 << CS), pin_oe_n_o);
    chk("pins", '1, pin_o);
    xfer(8'hA5, 8'h3C, 1'b0, 1'b1);
    xfer(8'h5A, 8'hC3, 1'b1, 1'b1);
    tick(5);
    chk("idle select", 40'h1, pin_o[CS]);
  endtask

  task automatic t_mode();
    setup(16'h0001, 8'h03, 1'b1);
    chk("idle clock", 40'h1, sclk);
    xfer(8'h81, 8'h7E, 1'b1, 1'b1);
  endtask

  task automatic t_off();
    snap = pin_oe_n_o;
    setup(SELECT_OFF_MIN, 8'h04, 1'b0);
    chk("enables", snap, pin_oe_n_o);
    xfer(8'h66, 8'h00, 1'b1, 1'b0);
    chk("pins", '1, pin_o);
  endtask

  task automatic t_meas();
    meas_i = '{1'b1, 1'b0, 1'b1, 1'b1};
    tick(1);
    meas_i.start = 1'b0;
    tick(5);
    chk("busy", 40'h1, meas_busy_o);
    monitor = 1'b1;
    tick(8);
    chk("done", 40'h1, meas_done_o);
    chk("busy", 40'h0, meas_busy_o);
    chk("count", 40'h7, meas_count_o);
    monitor = 1'b0;
    // Let the synced monitor fall before restarting, or it ends at once
    tick(4);
    for (int k = 0; k < 2; k++)
    begin
      meas_i.start = 1'b1;
      tick(1);
      meas_i.start = 1'b0;
      tick(3);
      chk("busy", 40'h1, meas_busy_o);
      abort = (k == 0);
      meas_i.stop = (k == 1);
      tick(1);
      abort = 1'b0;
      meas_i.stop = 1'b0;
      chk("excite", 40'h0, excite_o);
      tick(10);
      chk("busy", 40'h0, meas_busy_o);
    end
  endtask

  initial
  begin
    repeat (10) @(posedge mclk_i);
    #2;
    rst_n_i = 1'b1;
    t_cs();
    t_mode();
    t_off();
    t_meas();
    test_done();
  end
endmodule
